//--- include/dps_pkg.sv
// Shared constants, encodings and carrier types for the dot-product-subtract datapath.
// Assumes the issuing pipeline delivers one decoded instruction word with its two operands.
package dps_pkg;

	// Instruction field positions.
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int ZERO_HI = 15;
	localparam int ZERO_LO = 13;
	localparam int AC_HI = 12;
	localparam int AC_LO = 11;
	localparam int SUB_HI = 10;
	localparam int SUB_LO = 6;
	localparam int FUNC_HI = 5;
	localparam int FUNC_LO = 0;

	// Opcode, function and sub-operation encodings.
	localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h1F;
	localparam logic [5:0] FUNCTION_GROUP_A = 6'h30;
	localparam logic [5:0] FUNCTION_GROUP_B = 6'h34;
	localparam logic [4:0] SUB_LEFT = 5'h0B;
	localparam logic [4:0] SUB_RIGHT = 5'h0F;
	localparam logic [4:0] SUB_HALF_CROSS = 5'h09;
	localparam logic [4:0] SUB_FRAC_CROSS_SAT = 5'h1B;
	localparam logic [2:0] ZERO_FIELD = 3'h0;

	// Fixed-point limits.
	localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] Q31_MIN = 32'h80000000;
	localparam logic [15:0] Q15_MINUS_ONE = 16'h8000;

	// Position of the saturation flag field in the extension control word.
	localparam int OUFLAG_LSB = 16;

	// Reset values.
	localparam logic [127:0] ACC_RESET = 128'h0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Operation kinds after decode.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_OCT_LEFT,
		OP_OCT_RIGHT,
		OP_QUAD_LEFT,
		OP_QUAD_RIGHT,
		OP_HALF_CROSS,
		OP_FRAC_SAT
	} dps_op_t;

	// One issued instruction with its source operands.
	typedef struct packed {
		logic valid;
		logic [31:0] instr;
		logic [63:0] firstSourceReg;
		logic [63:0] secondSourceReg;
	} dps_issue_t;

	// Direct accumulator load from the pipeline.
	typedef struct packed {
		logic valid;
		logic [1:0] sel;
		logic [63:0] accHighHalf;
		logic [63:0] accLowHalf;
	} dps_acc_wr_t;

endpackage

//--- rtl/dps_byte_mult.sv
// Unsigned byte multiplier array: four byte-pair products of one 32-bit lane.
// Assumes both lanes come from logic on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module dps_byte_mult
	import dps_pkg::*;
(
	// Operand lanes.
	input wire logic [31:0] laneFirst,
	input wire logic [31:0] laneSecond,
	// Product sums.
	output logic [16:0] pairHigh,
	output logic [16:0] pairLow,
	output logic [17:0] quadSum
);

	// Multiplies two unsigned bytes into a 16-bit product.
	// Both operands are widened first, so the product never shrinks to eight bits.
	function automatic logic [15:0] unsignedByteMultiply(input logic [7:0] a, input logic [7:0] b);
		unsignedByteMultiply = {8'h00, a} * {8'h00, b};
	endfunction

	logic [15:0] prod3;
	logic [15:0] prod2;
	logic [15:0] prod1;
	logic [15:0] prod0;

	// Byte-pair products, high pair and low pair summed separately.
	always_comb begin
		prod3 = unsignedByteMultiply(laneFirst[31:24], laneSecond[31:24]);
		prod2 = unsignedByteMultiply(laneFirst[23:16], laneSecond[23:16]);
		prod1 = unsignedByteMultiply(laneFirst[15:8], laneSecond[15:8]);
		prod0 = unsignedByteMultiply(laneFirst[7:0], laneSecond[7:0]);
		pairHigh = {1'b0, prod3} + {1'b0, prod2};
		pairLow = {1'b0, prod1} + {1'b0, prod0};
		quadSum = {1'b0, pairHigh} + {1'b0, pairLow};
	end

endmodule // dps_byte_mult

`default_nettype wire

//--- rtl/dps_datapath.sv
// Dot-product-with-subtract execution datapath with four accumulators and flags.
// Assumes the pipeline issues at most one instruction per cycle from the clk domain.
//
// Behaviour
// [RL1] Positive overflow clamps to Q31 maximum, flag set.
// [RL2] Negative overflow clamps to Q31 minimum, flag set.
// [RL3] 64-bit result written back sign-extended per half.
// [RL4] Minus one squared gives Q31 max, flag set.
// [RL5] Otherwise Q15 product shifted left one bit.
// [RL6] Cross halfword products summed, subtracted from accumulator.
// [RL7] Left octal uses upper four byte pairs.
// [RL8] Octal sum subtracted from full 128 bits.
// [RL9] Right octal uses lower four byte pairs.
// [RL10] Left quad uses bytes 31..16, 64-bit subtract.
// [RL11] Right quad uses bytes 15..0, 64-bit subtract.
// [RL12] Unsigned byte variants never touch saturation flags.
// [RL13] Two-bit selector picks one of four accumulators.
// [RL14] Only reserved and disabled exceptions are raised.
// [RL15] Octal variants decode from function group B.
// [RL16] Quad variants decode from function group A.
// [RL17] Integer cross variant decodes sub-operation 01001.
// [RL18] Accumulator update completes before the next instruction.
`timescale 1ns/1ps
`default_nettype none

module dps_datapath
	import dps_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Instruction issue.
	input wire dps_issue_t issue,
	input wire logic extEnabled,
	// Direct accumulator load.
	input wire dps_acc_wr_t accWr,
	// Software write of the saturation flag field.
	input wire logic ctrlWrite,
	input wire logic [3:0] ctrlFlags,
	// Accumulator read port.
	input wire logic [1:0] readSel,
	// Results and status.
	output logic retired,
	output logic reservedExc,
	output logic disabledExc,
	output logic [3:0] satFlags,
	output logic [31:0] extensionControlWord,
	output logic [63:0] readHigh,
	output logic [63:0] readLow
);

	typedef struct packed {
		logic [3:0][127:0] acc;
		logic [3:0] satFlags;
		logic retired;
		logic reservedExc;
		logic disabledExc;
		logic [63:0] readHigh;
		logic [63:0] readLow;
	} dps_state_t;

	dps_state_t st;
	dps_state_t next_st;

	// Decodes the instruction word into an operation kind.
	function automatic dps_op_t decodeOp(input logic [31:0] w);
		decodeOp = OP_NONE;
		if (w[OPC_HI:OPC_LO] == MAJOR_OPCODE_GROUP && w[ZERO_HI:ZERO_LO] == ZERO_FIELD) begin
			if (w[FUNC_HI:FUNC_LO] == FUNCTION_GROUP_B) begin
				if (w[SUB_HI:SUB_LO] == SUB_LEFT) decodeOp = OP_OCT_LEFT; // [RL15]
				if (w[SUB_HI:SUB_LO] == SUB_RIGHT) decodeOp = OP_OCT_RIGHT; // [RL15]
			end
			if (w[FUNC_HI:FUNC_LO] == FUNCTION_GROUP_A) begin
				if (w[SUB_HI:SUB_LO] == SUB_LEFT) decodeOp = OP_QUAD_LEFT; // [RL16]
				if (w[SUB_HI:SUB_LO] == SUB_RIGHT) decodeOp = OP_QUAD_RIGHT; // [RL16]
				if (w[SUB_HI:SUB_LO] == SUB_HALF_CROSS) decodeOp = OP_HALF_CROSS; // [RL17]
				if (w[SUB_HI:SUB_LO] == SUB_FRAC_CROSS_SAT) decodeOp = OP_FRAC_SAT;
			end
		end
	endfunction

	// Signed 16 by 16 integer product.
	// Both operands are sign-extended to 32 bits first, so the product keeps its upper half.
	function automatic logic [31:0] halfMultiply(input logic [15:0] a, input logic [15:0] b);
		halfMultiply = {{16{a[15]}}, a} * {{16{b[15]}}, b};
	endfunction

	// Q15 fractional multiply; the top bit reports saturation.
	function automatic logic [32:0] fracHalfMultiply(input logic [15:0] a, input logic [15:0] b);
		if (a == Q15_MINUS_ONE && b == Q15_MINUS_ONE) begin
			fracHalfMultiply = {1'b1, Q31_MAX}; // [RL4]
		end else begin
			fracHalfMultiply = {1'b0, halfMultiply(a, b) << 1}; // [RL5]
		end
	endfunction

	// Packs a 64-bit result into the high and low halves, each sign-extended.
	function automatic logic [127:0] packResult(input logic [63:0] r);
		packResult = {{32{r[63]}}, r[63:32], {32{r[31]}}, r[31:0]}; // [RL3]
	endfunction

	dps_op_t opKind;
	logic [1:0] acSel;
	logic [127:0] accSelVal;
	logic [63:0] acc64;
	logic [63:0] srcFirst;
	logic [63:0] srcSecond;
	logic [32:0] fracB;
	logic [32:0] fracA;
	logic [63:0] fracDot;
	logic [63:0] fracDiff;
	logic [63:0] fracRes;
	logic fracSatMul;
	logic fracSatPos;
	logic fracSatNeg;
	logic [31:0] intB;
	logic [31:0] intA;
	logic [32:0] intDot;
	logic [63:0] intRes;
	logic [16:0] leftPairHigh;
	logic [17:0] leftQuad;
	logic [16:0] rightPairHigh;
	logic [16:0] rightPairLow;
	logic [17:0] rightQuad;
	logic [17:0] octDot;
	logic [63:0] quadRes;
	logic [127:0] newAcc;
	logic [3:0] flagSet;
	logic opTaken;

	// Byte products of the upper word of both sources.
	dps_byte_mult leftLane (
		.laneFirst(srcFirst[63:32]),
		.laneSecond(srcSecond[63:32]),
		.pairHigh(leftPairHigh),
		.pairLow(),
		.quadSum(leftQuad)
	);

	// Byte products of the lower word of both sources.
	dps_byte_mult rightLane (
		.laneFirst(srcFirst[31:0]),
		.laneSecond(srcSecond[31:0]),
		.pairHigh(rightPairHigh),
		.pairLow(rightPairLow),
		.quadSum(rightQuad)
	);

	// Operand selection and the arithmetic of every variant.
	always_comb begin
		srcFirst = issue.firstSourceReg;
		srcSecond = issue.secondSourceReg;
		opKind = decodeOp(issue.instr);
		acSel = issue.instr[AC_HI:AC_LO];
		accSelVal = st.acc[acSel]; // [RL13]
		acc64 = {accSelVal[95:64], accSelVal[31:0]};
		// Fractional cross products, high of first against low of second and back.
		fracB = fracHalfMultiply(srcFirst[31:16], srcSecond[15:0]); // [RL6]
		fracA = fracHalfMultiply(srcFirst[15:0], srcSecond[31:16]); // [RL6]
		fracSatMul = fracB[32] | fracA[32];
		fracDot = {{32{fracB[31]}}, fracB[31:0]} + {{32{fracA[31]}}, fracA[31:0]};
		fracDiff = acc64 - fracDot; // [RL6]
		fracSatPos = !fracDiff[63] && (fracDiff[62:31] != 32'h0);
		fracSatNeg = fracDiff[63] && (fracDiff[62:31] != 32'hFFFFFFFF);
		fracRes = fracDiff;
		if (fracSatPos) begin
			fracRes = {32'h0, Q31_MAX}; // [RL1]
		end
		if (fracSatNeg) begin
			fracRes = {32'hFFFFFFFF, Q31_MIN}; // [RL2]
		end
		// Integer cross products at full width.
		intB = halfMultiply(srcFirst[31:16], srcSecond[15:0]); // [RL17]
		intA = halfMultiply(srcFirst[15:0], srcSecond[31:16]);
		intDot = {intB[31], intB} + {intA[31], intA};
		intRes = acc64 - {{31{intDot[32]}}, intDot};
		// Octal sum picks the upper or lower word of bytes.
		octDot = (opKind == OP_OCT_LEFT) ? leftQuad : rightQuad; // [RL7] [RL9]
		// Quad sum picks the high or low pair of the lower word.
		quadRes = acc64 - {47'h0, (opKind == OP_QUAD_LEFT) ? rightPairHigh : rightPairLow}; // [RL10] [RL11]
		newAcc = accSelVal;
		flagSet = 4'h0;
		unique case (opKind)
			OP_OCT_LEFT, OP_OCT_RIGHT: begin
				newAcc = accSelVal - {110'h0, octDot}; // [RL8]
			end
			OP_QUAD_LEFT, OP_QUAD_RIGHT: begin
				newAcc = packResult(quadRes); // [RL3]
			end
			OP_HALF_CROSS: begin
				newAcc = packResult(intRes);
			end
			OP_FRAC_SAT: begin
				newAcc = packResult(fracRes); // [RL3]
				flagSet[acSel] = fracSatMul | fracSatPos | fracSatNeg; // [RL1] [RL2] [RL4]
			end
			OP_NONE: begin
				newAcc = accSelVal;
			end
		endcase
		opTaken = issue.valid && extEnabled && (opKind != OP_NONE);
	end

	// Next state: accumulator write, flags with set over clear, exceptions, readback.
	always_comb begin
		next_st = st;
		if (accWr.valid && !issue.valid) begin
			next_st.acc[accWr.sel] = {accWr.accHighHalf, accWr.accLowHalf};
		end
		if (opTaken) begin
			next_st.acc[acSel] = newAcc; // [RL18]
		end
		// Byte variants leave flagSet at zero, so only software alters the field then.
		next_st.satFlags = (ctrlWrite ? ctrlFlags : st.satFlags) | (opTaken ? flagSet : 4'h0); // [RL12]
		next_st.retired = opTaken;
		next_st.reservedExc = issue.valid && (opKind == OP_NONE); // [RL14]
		next_st.disabledExc = issue.valid && (opKind != OP_NONE) && !extEnabled; // [RL14]
		next_st.readHigh = st.acc[readSel][127:64];
		next_st.readLow = st.acc[readSel][63:0];
	end

	// State register.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st.acc <= {4{ACC_RESET}};
			st.satFlags <= FLAGS_RESET;
			st.retired <= 1'b0;
			st.reservedExc <= 1'b0;
			st.disabledExc <= 1'b0;
			st.readHigh <= 64'h0;
			st.readLow <= 64'h0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register.
	assign retired = st.retired;
	assign reservedExc = st.reservedExc;
	assign disabledExc = st.disabledExc;
	assign satFlags = st.satFlags;
	assign extensionControlWord = 32'(st.satFlags) << OUFLAG_LSB;
	assign readHigh = st.readHigh;
	assign readLow = st.readLow;

	// Positive overflow of the saturating cross variant clamps and flags.
	a_sat_pos_clamp: assert property (@(posedge clk) disable iff (reset) // [RL1]
		(opTaken && opKind == OP_FRAC_SAT && fracSatPos) |=>
		(st.acc[$past(acSel)] == {96'h0, Q31_MAX}) && st.satFlags[$past(acSel)])
		else $error("positive overflow not clamped or not flagged");

	// Negative overflow of the saturating cross variant clamps and flags.
	a_sat_neg_clamp: assert property (@(posedge clk) disable iff (reset) // [RL2]
		(opTaken && opKind == OP_FRAC_SAT && fracSatNeg) |=>
		(st.acc[$past(acSel)] == {{96{1'b1}}, Q31_MIN}) && st.satFlags[$past(acSel)])
		else $error("negative overflow not clamped or not flagged");

	// A 64-bit variant leaves both halves sign-extended.
	a_half_sign_extend: assert property (@(posedge clk) disable iff (reset) // [RL3]
		(opTaken && opKind inside {OP_QUAD_LEFT, OP_QUAD_RIGHT, OP_HALF_CROSS, OP_FRAC_SAT}) |=>
		(st.acc[$past(acSel)][127:96] == {32{st.acc[$past(acSel)][95]}}) &&
		(st.acc[$past(acSel)][63:32] == {32{st.acc[$past(acSel)][31]}}))
		else $error("accumulator halves not sign-extended");

	// Minus one times minus one in either product raises the flag.
	a_minus_one_flag: assert property (@(posedge clk) disable iff (reset) // [RL4]
		(opTaken && opKind == OP_FRAC_SAT &&
		((srcFirst[31:16] == Q15_MINUS_ONE && srcSecond[15:0] == Q15_MINUS_ONE) ||
		(srcFirst[15:0] == Q15_MINUS_ONE && srcSecond[31:16] == Q15_MINUS_ONE))) |=>
		st.satFlags[$past(acSel)] && extensionControlWord[OUFLAG_LSB + $past(acSel)])
		else $error("Q15 minus one product did not set the flag");

	// Byte variants keep the flag field unless software writes it.
	a_byte_flags_kept: assert property (@(posedge clk) disable iff (reset) // [RL12]
		(opTaken && opKind inside {OP_OCT_LEFT, OP_OCT_RIGHT, OP_QUAD_LEFT, OP_QUAD_RIGHT} &&
		!ctrlWrite) |=> $stable(st.satFlags))
		else $error("byte variant changed the saturation flags");

	// Octal variants subtract the zero-extended sum from all 128 bits.
	a_oct_subtract: assert property (@(posedge clk) disable iff (reset) // [RL8]
		(opTaken && opKind inside {OP_OCT_LEFT, OP_OCT_RIGHT}) |=>
		(st.acc[$past(acSel)] == $past(accSelVal) - {110'h0, $past(octDot)}))
		else $error("octal subtract result wrong");

	// With accumulator 0 selected, an operation leaves accumulators 1 to 3 unchanged.
	a_other_acc_kept: assert property (@(posedge clk) disable iff (reset) // [RL13]
		(opTaken && acSel == 2'h0) |=>
		(st.acc[1] == $past(st.acc[1])) && (st.acc[2] == $past(st.acc[2])) &&
		(st.acc[3] == $past(st.acc[3])))
		else $error("unselected accumulator modified");

	// An undecodable word raises the reserved exception and changes nothing.
	a_reserved_exc: assert property (@(posedge clk) disable iff (reset) // [RL14]
		(issue.valid && opKind == OP_NONE) |=>
		reservedExc && !retired && !disabledExc && $stable(st.acc))
		else $error("reserved instruction not reported");

	// An accepted operation retires on the next edge with its accumulator already written.
	a_retire_next: assert property (@(posedge clk) disable iff (reset) // [RL18]
		opTaken |=> retired && !reservedExc && !disabledExc &&
		(st.acc[$past(acSel)] == $past(newAcc)))
		else $error("operation did not retire in one cycle");

	// A decodable word while the extension is off raises only the disabled exception.
	a_disabled_exc: assert property (@(posedge clk) disable iff (reset) // [RL14]
		(issue.valid && opKind != OP_NONE && !extEnabled && !ctrlWrite) |=>
		disabledExc && !retired && !reservedExc && $stable(st.acc) && $stable(st.satFlags))
		else $error("disabled issue not reported or state changed");

	// At most one answer pulse stands in any cycle.
	a_one_answer: assert property (@(posedge clk) disable iff (reset) // [RL14]
		$onehot0({retired, reservedExc, disabledExc}))
		else $error("more than one answer pulse at once");

	// A direct load with no issue in the same cycle lands in the selected accumulator.
	a_acc_load: assert property (@(posedge clk) disable iff (reset) // [RL13]
		(accWr.valid && !issue.valid) |=>
		(st.acc[$past(accWr.sel)] == $past({accWr.accHighHalf, accWr.accLowHalf})))
		else $error("direct accumulator load lost");

	// The read port shows the selected accumulator as of the previous edge.
	a_read_port: assert property (@(posedge clk) disable iff (reset) // [RL13]
		1'b1 |=> ({readHigh, readLow} == $past(st.acc[readSel])))
		else $error("read port does not follow the selected accumulator");

	// A flag set by an operation survives a software write in the same cycle.
	a_flag_set_wins: assert property (@(posedge clk) disable iff (reset) // [RL4]
		(opTaken && flagSet != 4'h0) |=> ((satFlags & $past(flagSet)) == $past(flagSet)))
		else $error("operation flag lost to a software write");

	// After the saturating cross variant the 64-bit result lies within the Q31 range.
	a_frac_in_range: assert property (@(posedge clk) disable iff (reset) // [RL1] [RL2]
		(opTaken && opKind == OP_FRAC_SAT) |=>
		(st.acc[$past(acSel)][95:64] == {32{st.acc[$past(acSel)][31]}}))
		else $error("saturating result outside the Q31 range");

	// The integer cross variant never touches the flag field.
	a_int_cross_flags: assert property (@(posedge clk) disable iff (reset) // [RL17]
		(opTaken && opKind == OP_HALF_CROSS && !ctrlWrite) |=> $stable(st.satFlags))
		else $error("integer cross variant changed the saturation flags");

endmodule // dps_datapath

`default_nettype wire

//--- verif/dps_pipe_model.sv
// Pipeline model that offers decoded instructions and collects the answer pulse.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module dps_pipe_model
	import dps_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Issue port.
	output var dps_issue_t issue,
	// Answer pulses.
	input wire logic retired,
	input wire logic reservedExc,
	input wire logic disabledExc
);
	// Nothing is offered before the first call.
	initial issue = '0;

	// Holds one word for one edge, then reads the pulse in the following cycle.
	task automatic send(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
			output logic [2:0] ans);
		issue = '{1'b1, w, a, b};
		@(negedge clk);
		ans = {retired, reservedExc, disabledExc};
	endtask

	// Withdraws the offer and inverts the lines so stale operands are never reused.
	task automatic idle();
		issue = '{1'b0, ~issue.instr, ~issue.firstSourceReg, ~issue.secondSourceReg};
	endtask
endmodule // dps_pipe_model

`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the dot-product-subtract datapath.
// Assumes the pipeline model drives the issue port.
`timescale 1ns/1ps
`default_nettype none

module tb
	import dps_pkg::*;
();
	logic clk, reset, extEnabled, ctrlWrite, retired, reservedExc, disabledExc;
	logic [3:0] ctrlFlags, satFlags, ef;
	logic [1:0] readSel;
	logic [31:0] extensionControlWord;
	logic [63:0] readHigh, readLow;
	dps_issue_t issue;
	dps_acc_wr_t accWr;
	int miscompares = 0;
	int checkCount = 0;

	// Clock of 25 ns period.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Block under test and its pipeline partner.
	dps_datapath i_dps_datapath (.clk(clk), .reset(reset), .issue(issue),
		.extEnabled(extEnabled), .accWr(accWr), .ctrlWrite(ctrlWrite), .ctrlFlags(ctrlFlags),
		.readSel(readSel), .retired(retired), .reservedExc(reservedExc),
		.disabledExc(disabledExc), .satFlags(satFlags),
		.extensionControlWord(extensionControlWord), .readHigh(readHigh), .readLow(readLow));
	dps_pipe_model i_dps_pipe_model (.clk(clk), .issue(issue), .retired(retired),
		.reservedExc(reservedExc), .disabledExc(disabledExc));

	// Counts every comparison and reports a mismatch.
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checkCount++;
		if (seen !== exp)
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			miscompares++;
	endtask

	// Builds an instruction word for one operation and accumulator.
	function automatic logic [31:0] word(input dps_op_t k, input logic [1:0] s);
		logic [4:0] sub;
		sub = (k == OP_OCT_LEFT || k == OP_QUAD_LEFT) ? SUB_LEFT : SUB_RIGHT;
		if (k == OP_HALF_CROSS)
			sub = SUB_HALF_CROSS;
		if (k == OP_FRAC_SAT)
			sub = SUB_FRAC_CROSS_SAT;
		return {MAJOR_OPCODE_GROUP, 10'h000, ZERO_FIELD, s, sub,
			(k == OP_OCT_LEFT || k == OP_OCT_RIGHT) ? FUNCTION_GROUP_B : FUNCTION_GROUP_A};
	endfunction

	// Fractional halfword product with its saturation mark on top.
	function automatic logic [32:0] q15(input logic [15:0] x, input logic [15:0] y);
		if (x == Q15_MINUS_ONE && y == Q15_MINUS_ONE)
			return {1'b1, Q31_MAX};
		return {1'b0, ({{16{x[15]}}, x} * {{16{y[15]}}, y}) << 1};
	endfunction

	// Spreads a 64-bit result over both halves with sign extension.
	function automatic logic [127:0] wb(input logic [63:0] t);
		return {{32{t[63]}}, t[63:32], {32{t[31]}}, t[31:0]};
	endfunction

	// Reference result with the expected flag bit on top.
	function automatic logic [128:0] ref_op(input dps_op_t k, input logic [127:0] acc,
			input logic [63:0] a, input logic [63:0] b);
		logic [63:0] t, d;
		logic [32:0] pB, pA;
		logic [31:0] la, lb;
		logic oct;
		oct = (k == OP_OCT_LEFT || k == OP_OCT_RIGHT);
		la = (k == OP_OCT_LEFT) ? a[63:32] : a[31:0];
		lb = (k == OP_OCT_LEFT) ? b[63:32] : b[31:0];
		pB = q15(a[31:16], b[15:0]);
		pA = q15(a[15:0], b[31:16]);
		d = 64'h0;
		for (int i = 0; i < 4; i++)
			if (oct || (k == OP_QUAD_LEFT && i > 1) || (k == OP_QUAD_RIGHT && i < 2))
				d = d + la[8*i+:8] * lb[8*i+:8];
		if (k == OP_HALF_CROSS)
			d = {{48{a[31]}}, a[31:16]} * {{48{b[15]}}, b[15:0]}
				+ {{48{a[15]}}, a[15:0]} * {{48{b[31]}}, b[31:16]};
		if (k == OP_FRAC_SAT)
			d = {{32{pB[31]}}, pB[31:0]} + {{32{pA[31]}}, pA[31:0]};
		if (oct)
			return {1'b0, acc - {64'h0, d}};
		t = {acc[95:64], acc[31:0]} - d;
		if (k == OP_FRAC_SAT && !t[63] && t[62:31] != 32'h0)
			return {1'b1, wb({32'h0, Q31_MAX})};
		if (k == OP_FRAC_SAT && t[63] && t[62:31] != 32'hFFFFFFFF)
			return {1'b1, wb({32'hFFFFFFFF, Q31_MIN})};
		return {k == OP_FRAC_SAT && (pA[32] || pB[32]), wb(t)};
	endfunction

	// Loads one accumulator through the direct load port.
	task automatic ld(input logic [1:0] s, input logic [127:0] v);
		@(negedge clk);
		accWr = '{1'b1, s, v[127:64], v[63:0]};
		@(negedge clk);
		accWr.valid = 1'b0;
	endtask

	// Reads one accumulator back after one edge.
	task automatic rd(input logic [1:0] s, output logic [127:0] v);
		readSel = s;
		@(negedge clk);
		v = {readHigh, readLow};
	endtask

	// Loads, executes one operation and judges answer, flags and accumulator.
	task automatic run(input dps_op_t k, input logic [1:0] s, input logic [127:0] acc,
			input logic [63:0] a, input logic [63:0] b);
		logic [128:0] e;
		logic [2:0] ans;
		logic [127:0] v;
		e = ref_op(k, acc, a, b);
		ld(s, acc);
		i_dps_pipe_model.send(word(k, s), a, b, ans);
		ef[s] = ef[s] | e[128];
		check(ans, 3'h4);
		check(satFlags, ef);
		check(extensionControlWord, {12'h000, ef, 16'h0000});
		i_dps_pipe_model.idle();
		rd(s, v);
		check(v, e[127:0]);
	endtask

	// Octal byte variants on every accumulator, quad variants on accumulators 1 and 2, with borrows across the halves.
	task automatic sc_bytes();
		for (int s = 0; s < 4; s++) begin
			run(OP_OCT_LEFT, 2'(s), 128'h0, 64'hFFFFFFFF_01020304, 64'hFFFFFFFF_05060708);
			run(OP_OCT_RIGHT, 2'(s), {64'h1, 64'h0}, 64'h01020304_FFFFFFFF, 64'h0A0B_FFFFFFFF);
		end
		run(OP_QUAD_LEFT, 2'h1, {64'hAAAA5555_00000000, 64'h1}, 64'hFFFF0102, 64'hFFFF0304);
		run(OP_QUAD_RIGHT, 2'h2, {64'h0, 64'h80000100}, 64'hFF0102FF, 64'hFF0304FF);
	endtask

	// Saturating fractional cross on both clamps, the minus-one product and the plain case.
	task automatic sc_frac();
		run(OP_FRAC_SAT, 2'h0, {64'h0, 64'h7FFFFFFF}, 64'h7FFF0000, 64'h00008001);
		run(OP_FRAC_SAT, 2'h1, {64'hFFFFFFFF, 64'h80000000}, 64'h7FFF7FFF, 64'h7FFF7FFF);
		run(OP_FRAC_SAT, 2'h2, {64'h0, 64'h7FFFFFFF}, 64'h80000000, 64'h00008000);
		run(OP_FRAC_SAT, 2'h3, {64'hFFFFFFFF, 64'hC0000000}, 64'h00038000, 64'h7FFF0002);
		run(OP_HALF_CROSS, 2'h3, 128'h0, 64'hFFFF8000, 64'h80007FFF);
	endtask

	// Two operations back to back on one accumulator.
	task automatic sc_b2b();
		logic [2:0] ans;
		logic [127:0] v;
		logic [128:0] e;
		e = ref_op(OP_QUAD_RIGHT, {64'h0, 64'h100}, 64'hFFFF, 64'hFFFF);
		e = ref_op(OP_HALF_CROSS, e[127:0], 64'h00020003, 64'h00040005);
		ld(2'h1, {64'h0, 64'h100});
		i_dps_pipe_model.send(word(OP_QUAD_RIGHT, 2'h1), 64'hFFFF, 64'hFFFF, ans);
		i_dps_pipe_model.send(word(OP_HALF_CROSS, 2'h1), 64'h00020003, 64'h00040005, ans);
		i_dps_pipe_model.idle();
		rd(2'h1, v);
		check(v, e[127:0]);
	endtask

	// Load and flag write in the issue cycle: the load is dropped and the set wins.
	task automatic sc_race();
		logic [2:0] ans;
		logic [127:0] v;
		logic [128:0] e;
		e = ref_op(OP_FRAC_SAT, 128'h0, 64'h80008000, 64'h80008000);
		ld(2'h2, 128'h0);
		@(negedge clk);
		accWr = '{1'b1, 2'h2, 64'h5, 64'h6};
		{ctrlFlags, ctrlWrite} = 5'h01;
		i_dps_pipe_model.send(word(OP_FRAC_SAT, 2'h2), 64'h80008000, 64'h80008000, ans);
		{accWr.valid, ctrlWrite} = 2'h0;
		ef = 4'h4;
		check(ans, 3'h4);
		check(satFlags, ef);
		i_dps_pipe_model.idle();
		rd(2'h2, v);
		check(v, e[127:0]);
	endtask

	// Flag write, then a reserved word and a disabled issue that must change nothing.
	task automatic sc_ctl();
		logic [2:0] ans;
		logic [127:0] v;
		ld(2'h0, {64'h3, 64'h4});
		ctrlFlags = 4'hA;
		ctrlWrite = 1'b1;
		@(negedge clk);
		ctrlWrite = 1'b0;
		ef = 4'hA;
		check(satFlags, ef);
		i_dps_pipe_model.send(word(OP_FRAC_SAT, 2'h0) | 32'h2000, 64'h80008000, 64'h80008000, ans);
		check(ans, 3'h2);
		extEnabled = 1'b0;
		i_dps_pipe_model.send(word(OP_FRAC_SAT, 2'h0), 64'h80008000, 64'h80008000, ans);
		check(ans, 3'h1);
		check(satFlags, ef);
		i_dps_pipe_model.idle();
		extEnabled = 1'b1;
		rd(2'h0, v);
		check(v, {64'h3, 64'h4});
	endtask

	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (miscompares == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence after 20 cycles of reset.
	initial begin
		{reset, extEnabled, ctrlWrite, ctrlFlags, readSel, ef} = {2'h3, 11'h0};
		accWr = '0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		check({retired, reservedExc, disabledExc, satFlags}, 7'h00);
		sc_bytes();
		sc_frac();
		sc_b2b();
		sc_race();
		sc_ctl();
		print_verdict();
	end

	// Watchdog well beyond the hundred or so cycles the tests need.
	initial begin
		#(25 * 2000);
		miscompares++;
		print_verdict();
	end
endmodule // tb

`default_nettype wire
